// [rfc_dev.sv]
/*
 * Device end: receive data and status FIFOs drained over the link,
 * end-alignment padding, down-counting DMA word count with interrupt,
 * force discard, and indirect access to internal MAC registers.
 * Assumes a host that holds req until ack and one clock for all.
 */
// How it works
// R1: Alignment code picks 4, 16 or 32 bytes
// R2: Device appends filler words up to boundary
// R3: Host discards filler after last real word
// R4: Host sets alignment only between packets
// R5: Twelve-bit word count raises DMA interrupt
// R6: Count drops one per word read
// R7: Rewriting count restarts countdown from new value
// R8: Discard empties both FIFOs, pointers zero
// R9: Discard bit reads zero, self-clearing
// R10: MAC registers reached via command/data pair
// R11: Enable bit 20 gates DMA interrupt
// R12: Reserved bits zero; code 11 means 4-byte
`timescale 1ns/100ps
`default_nettype none
module rfc_dev
	import rfc_pkg::*;
#(
	parameter int DATA_DEPTH = 16,
	parameter int STAT_DEPTH = 4,
	parameter int MAC_REGS   = 8
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	rfc_link_if.dev          link,
	input  wire logic [31:0] rx_data_i,
	input  wire logic        rx_last_i,
	input  wire logic        rx_valid_i,
	output logic             rx_ready_o
);
	localparam int DAW = $clog2(DATA_DEPTH);
	localparam int SAW = $clog2(STAT_DEPTH);
	localparam int MAW = $clog2(MAC_REGS);

	logic [32:0]          dmem [DATA_DEPTH];
	logic [31:0]          smem [STAT_DEPTH];
	logic [31:0]          mac_q [MAC_REGS];
	logic [DAW:0]         dwp_q, drp_q;
	logic [SAW:0]         swp_q, srp_q;
	logic [15:0]          plen_q;
	logic [2:0]           bcnt_q, pad_q, amask, nfill;
	logic [1:0]           ea_q;
	logic [RFC_CNT_W-1:0] cnt_q;
	logic                 sts_q, en_q, ack_q;
	logic [31:0]          rdata_q, mdata_q;
	logic                 mbusy_q, mread_q;
	logic [MAW-1:0]       midx_q;
	logic                 d_empty, d_full, s_empty, s_full, push;
	logic                 take, wr, rd, data_rd, filler, pop, word_rd;
	logic                 cfg_wr, discard, stat_rd, rxd_evt;

	// FIFO occupancy from pointers with a wrap bit
	assign d_empty = dwp_q == drp_q;
	assign d_full  = (dwp_q[DAW] != drp_q[DAW]) && (dwp_q[DAW-1:0] == drp_q[DAW-1:0]);
	assign s_empty = swp_q == srp_q;
	assign s_full  = (swp_q[SAW] != srp_q[SAW]) && (swp_q[SAW-1:0] == srp_q[SAW-1:0]);
	// Last word also needs a status slot, so stall it on a full status FIFO
	assign rx_ready_o = !d_full && !(rx_last_i && s_full);
	assign push       = rx_valid_i && rx_ready_o;

	// Link decode; ack_q blocks re-taking the still-held request
	assign take    = link.req && !ack_q;
	assign wr      = take && link.we;
	assign rd      = take && !link.we;
	assign data_rd = rd && link.addr == RFC_OFF_RX_DATA;
	assign stat_rd = rd && link.addr == RFC_OFF_RX_STAT && !s_empty;
	assign filler  = pad_q != 3'h0;
	assign pop     = data_rd && !filler && !d_empty;
	assign word_rd = pop || (data_rd && filler);
	assign cfg_wr  = wr && link.addr == RFC_OFF_RX_CFG;
	assign discard = cfg_wr && link.wdata[RFC_DISCARD_BIT]; // R8

	// Boundary in words less one; reserved code falls back to 4 bytes
	always_comb begin
		unique case (ea_q) // R1
			RFC_EA_16B: amask = 3'h3;
			RFC_EA_32B: amask = 3'h7;
			default:    amask = 3'h0; // R12
		endcase
		nfill = (3'h0 - (bcnt_q + 3'h1)) & amask; // R2
	end

	// Data FIFO storage; bit 32 marks the last word of a buffer
	always_ff @(posedge clk_i) begin
		if (push) begin
			dmem[dwp_q[DAW-1:0]] <= {rx_last_i, rx_data_i};
		end
	end

	// Status FIFO storage: word length of each buffer
	always_ff @(posedge clk_i) begin
		if (push && rx_last_i) begin
			smem[swp_q[SAW-1:0]] <= {16'h0000, plen_q + 16'h0001};
		end
	end

	// Pointers; discard wins over a push or pop in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dwp_q  <= '0;
			drp_q  <= '0;
			swp_q  <= '0;
			srp_q  <= '0;
			plen_q <= 16'h0000;
		end else if (discard) begin
			dwp_q  <= '0; // R8
			drp_q  <= '0;
			swp_q  <= '0;
			srp_q  <= '0;
			plen_q <= 16'h0000;
		end else begin
			if (push) begin
				dwp_q  <= dwp_q + 1'b1;
				plen_q <= rx_last_i ? 16'h0000 : plen_q + 16'h0001;
			end
			if (push && rx_last_i) begin
				swp_q <= swp_q + 1'b1;
			end
			if (pop) begin
				drp_q <= drp_q + 1'b1;
			end
			if (stat_rd) begin
				srp_q <= srp_q + 1'b1;
			end
		end
	end

	// Buffer position and pending filler words
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bcnt_q <= 3'h0;
			pad_q  <= 3'h0;
		end else if (discard) begin
			bcnt_q <= 3'h0;
			pad_q  <= 3'h0;
		end else if (data_rd && filler) begin
			pad_q <= pad_q - 3'h1; // R2
		end else if (pop && dmem[drp_q[DAW-1:0]][32]) begin
			pad_q  <= nfill; // R2
			bcnt_q <= 3'h0;
		end else if (pop) begin
			bcnt_q <= bcnt_q + 3'h1;
		end
	end

	// Alignment setting; host must not change it mid-packet
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ea_q <= RFC_EA_RST;
		end else if (cfg_wr) begin
			ea_q <= link.wdata[RFC_EA_LO +: 2]; // R1
		end
	end

	// DMA word count; a write restarts it from the new value
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= RFC_CNT_RST;
		end else if (cfg_wr) begin
			cnt_q <= link.wdata[RFC_CNT_LO +: RFC_CNT_W]; // R7
		end else if (word_rd && cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1; // R6
		end
	end
	assign rxd_evt = word_rd && !cfg_wr && cnt_q == RFC_CNT_W'(1); // R5

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sts_q <= 1'b0;
			en_q  <= 1'b0;
		end else begin
			if (rxd_evt) begin
				sts_q <= 1'b1; // R5
			end else if (wr && link.addr == RFC_OFF_INT_STS && link.wdata[RFC_RXD_INT_BIT]) begin
				sts_q <= 1'b0;
			end
			if (wr && link.addr == RFC_OFF_INT_EN) begin
				en_q <= link.wdata[RFC_RXD_INT_BIT];
			end
		end
	end
	assign link.irq = sts_q && en_q; // R11

	// Indirect MAC access: command kicks a one-cycle transfer
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mbusy_q <= 1'b0;
			mread_q <= 1'b0;
			midx_q  <= '0;
			mdata_q <= 32'h0000_0000;
		end else if (mbusy_q) begin
			mbusy_q <= 1'b0;
			if (mread_q) begin
				mdata_q <= mac_q[midx_q]; // R10
			end
		end else if (wr && link.addr == RFC_OFF_MAC_CMD && link.wdata[RFC_MCMD_BUSY]) begin
			mbusy_q <= 1'b1; // R10
			mread_q <= link.wdata[RFC_MCMD_READ];
			midx_q  <= link.wdata[MAW-1:0];
		end else if (wr && link.addr == RFC_OFF_MAC_DATA) begin
			mdata_q <= link.wdata;
		end
	end

	// MAC register bank, written only through the command path
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int i = 0; i < MAC_REGS; i++) begin
				mac_q[i] <= 32'h0000_0000;
			end
		end else if (mbusy_q && !mread_q) begin
			mac_q[midx_q] <= mdata_q;
		end
	end

	// Read answer, registered; unmapped and underrun read zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= take;
			if (rd) begin
				unique case (link.addr)
					RFC_OFF_RX_DATA:  rdata_q <= pop ? dmem[drp_q[DAW-1:0]][31:0] : 32'h0000_0000;
					RFC_OFF_RX_STAT:  rdata_q <= s_empty ? 32'h0000_0000 : smem[srp_q[SAW-1:0]];
					RFC_OFF_INT_STS:  rdata_q <= 32'(sts_q) << RFC_RXD_INT_BIT;
					RFC_OFF_INT_EN:   rdata_q <= 32'(en_q) << RFC_RXD_INT_BIT;
					// Discard and reserved bits read zero
					RFC_OFF_RX_CFG:   rdata_q <= {ea_q, 2'h0, cnt_q, 16'h0000}; // R9 R12
					RFC_OFF_MAC_CMD:  rdata_q <= {mbusy_q, mread_q, 30'(midx_q)};
					RFC_OFF_MAC_DATA: rdata_q <= mdata_q;
					default:          rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
	assign link.ack   = ack_q;
	assign link.rdata = rdata_q;
endmodule
`default_nettype wire

// [rfc_host.sv]
/*
 * Host end: AXI4-Lite slave whose registers order single link accesses,
 * drop filler words after the real words of a packet, and hold back
 * alignment changes while a packet is partly read.
 * Assumes the device acks each held request with a one-cycle pulse.
 */
`timescale 1ns/100ps
`default_nettype none
module rfc_host
	import rfc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	rfc_link_if.host         link,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [4:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	rfc_hstate_e st_q;
	logic        aw_got_q, w_got_q, we_q, req_q, filler_q, refused_q;
	logic [4:0]  awaddr_q;
	logic [31:0] wbuf_q, wdata_q, rdata_q;
	logic [7:0]  addr_q;
	logic [15:0] left_q;
	logic        do_wr, go, hold_cfg;

	// Write channels taken in either order, answered once both are in
	assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
	assign s_axi_bresp   = 2'b00;
	assign s_axi_rresp   = 2'b00;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_wr         = aw_got_q && w_got_q && !s_axi_bvalid;
	assign go            = do_wr && awaddr_q == RFC_H_CMD && st_q == RFC_H_IDLE;
	// Alignment must stay put while real words of a packet remain
	assign hold_cfg      = wbuf_q[RFC_HC_WRITE] && wbuf_q[7:0] == RFC_OFF_RX_CFG && left_q != 16'h0000; // R4

	// AXI write handshake
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_got_q     <= 1'b0;
			w_got_q      <= 1'b0;
			awaddr_q     <= 5'h00;
			wbuf_q       <= 32'h0000_0000;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_q <= 1'b1;
				wbuf_q  <= s_axi_wdata;
			end
			if (do_wr) begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Link sequencer: one access at a time, request held until ack
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q   <= RFC_H_IDLE;
			req_q  <= 1'b0;
			we_q   <= 1'b0;
			addr_q <= 8'h00;
		end else begin
			unique case (st_q)
				RFC_H_IDLE: begin
					if (go && !hold_cfg) begin
						st_q   <= RFC_H_WAIT;
						req_q  <= 1'b1;
						we_q   <= wbuf_q[RFC_HC_WRITE];
						addr_q <= wbuf_q[7:0];
					end
				end
				RFC_H_WAIT: begin
					if (link.ack) begin
						st_q  <= RFC_H_IDLE;
						req_q <= 1'b0;
					end
				end
			endcase
		end
	end
	assign link.req   = req_q;
	assign link.we    = we_q;
	assign link.addr  = addr_q;
	assign link.wdata = wdata_q;

	// Software registers, packet word budget and read result
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wdata_q   <= 32'h0000_0000;
			rdata_q   <= 32'h0000_0000;
			left_q    <= 16'h0000;
			filler_q  <= 1'b0;
			refused_q <= 1'b0;
		end else begin
			if (do_wr && awaddr_q == RFC_H_WDATA) begin
				wdata_q <= wbuf_q;
			end
			if (go) begin
				refused_q <= hold_cfg; // R4
				filler_q  <= 1'b0;
			end
			// Read result never lost to a budget write in the same cycle
			if (st_q == RFC_H_WAIT && link.ack && !we_q) begin
				if (addr_q != RFC_OFF_RX_DATA || left_q != 16'h0000) begin
					rdata_q <= link.rdata;
				end else begin
					filler_q <= 1'b1; // R3
				end
				if (addr_q == RFC_OFF_RX_DATA && left_q != 16'h0000) begin
					left_q <= left_q - 16'h0001;
				end
			end
			// A software budget write wins over the decrement
			if (do_wr && awaddr_q == RFC_H_PKT_LEFT) begin
				left_q <= wbuf_q[15:0];
			end
		end
	end

	// AXI read answer; unmapped offsets read zero
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			unique case (s_axi_araddr)
				RFC_H_CMD:      s_axi_rdata <= {23'h000000, we_q, addr_q};
				RFC_H_WDATA:    s_axi_rdata <= wdata_q;
				RFC_H_RDATA:    s_axi_rdata <= rdata_q;
				RFC_H_STATUS:   s_axi_rdata <= {28'h0000000, refused_q, filler_q, link.irq, st_q == RFC_H_WAIT};
				RFC_H_PKT_LEFT: s_axi_rdata <= {16'h0000, left_q};
				default:        s_axi_rdata <= 32'h0000_0000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// [rfc_link_checker.sv]
/* Link protocol and register checks between host and device ends.
   Assumes one clock, active-low async reset, signals seen as plain inputs. */
`timescale 1ns/100ps
`default_nettype none
module rfc_link_checker
	import rfc_pkg::*;
(
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        req,
	input wire logic        we,
	input wire logic [7:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic        ack,
	input wire logic [31:0] rdata,
	input wire logic        irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Request taken, and its one-cycle answer
	sequence taken_s;
		req && !ack;
	endsequence
	sequence answered_s;
		ack ##1 (!ack && !req);
	endsequence
	// Answer exactly one cycle after the take
	link_answer_a: assert property (taken_s |=> ack && req) else $error("link answer late");
	ack_pulse_a: assert property (ack |-> answered_s) else $error("ack not a pulse");
	req_hold_a: assert property (taken_s |=> $stable(addr) && $stable(we) && $stable(wdata))
		else $error("request changed while pending");
	// Interrupt moves only with an access
	irq_rise_a: assert property ($rose(irq) |-> ack) else $error("irq rose without access");
	irq_fall_a: assert property ($fell(irq) |-> ack && we) else $error("irq fell without write");
	// Reserved and self-clearing bits read zero; irq low while enable or flag reads zero
	cfg_zero_a: assert property (ack && !we && addr == RFC_OFF_RX_CFG |->
		rdata[29:28] == 2'h0 && rdata[15:0] == 16'h0) else $error("config reserved bits set");
	en_gate_a: assert property (ack && !we && addr == RFC_OFF_INT_EN && !rdata[RFC_RXD_INT_BIT] |-> !irq)
		else $error("irq while disabled");
	sts_gate_a: assert property (ack && !we && addr == RFC_OFF_INT_STS && !rdata[RFC_RXD_INT_BIT] |-> !irq)
		else $error("irq without flag");
endmodule
`default_nettype wire

// [rfc_link_if.sv]
/*
 * Register link between the host end and the device end.
 * Assumes both ends share clk and nrst; request held until ack pulse.
 */
`timescale 1ns/100ps
`default_nettype none
interface rfc_link_if (
	input wire logic clk,
	input wire logic nrst
);
	logic        req;
	logic        we;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        ack;
	logic [31:0] rdata;
	logic        irq;

	modport dev  (input req, we, addr, wdata, output ack, rdata, irq);
	modport host (output req, we, addr, wdata, input ack, rdata, irq);
endinterface
`default_nettype wire

// [rfc_pkg.sv]
/*
 * Shared constants for the receive FIFO read configuration block:
 * link register map, field positions, reset values, host command map.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package rfc_pkg;
	// Device register map on the link (byte offsets)
	localparam logic [7:0]  RFC_OFF_RX_DATA  = 8'h00;
	localparam logic [7:0]  RFC_OFF_RX_STAT  = 8'h40;
	localparam logic [7:0]  RFC_OFF_INT_STS  = 8'h58;
	localparam logic [7:0]  RFC_OFF_INT_EN   = 8'h5c;
	localparam logic [7:0]  RFC_OFF_RX_CFG   = 8'h6c;
	localparam logic [7:0]  RFC_OFF_MAC_CMD  = 8'ha4;
	localparam logic [7:0]  RFC_OFF_MAC_DATA = 8'ha8;
	// Receive configuration fields
	localparam int          RFC_EA_LO        = 30;
	localparam int          RFC_CNT_LO       = 16;
	localparam int          RFC_CNT_W        = 12;
	localparam int          RFC_DISCARD_BIT  = 15;
	localparam logic [1:0]  RFC_EA_4B        = 2'h0;
	localparam logic [1:0]  RFC_EA_16B       = 2'h1;
	localparam logic [1:0]  RFC_EA_32B       = 2'h2;
	// Interrupt status / enable position
	localparam int          RFC_RXD_INT_BIT  = 20;
	// Indirect MAC register command fields
	localparam int          RFC_MCMD_BUSY    = 31;
	localparam int          RFC_MCMD_READ    = 30;
	// Reset values
	localparam logic [31:0] RFC_RX_CFG_RST   = 32'h0000_0000;
	localparam logic [1:0]  RFC_EA_RST       = 2'h0;
	localparam logic [11:0] RFC_CNT_RST      = 12'h000;
	// Host AXI4-Lite register map (byte offsets)
	localparam logic [4:0]  RFC_H_CMD        = 5'h00;
	localparam logic [4:0]  RFC_H_WDATA      = 5'h04;
	localparam logic [4:0]  RFC_H_RDATA      = 5'h08;
	localparam logic [4:0]  RFC_H_STATUS     = 5'h0c;
	localparam logic [4:0]  RFC_H_PKT_LEFT   = 5'h10;
	// Host command fields
	localparam int          RFC_HC_WRITE     = 8;
	// Host status bits
	localparam int          RFC_HS_BUSY      = 0;
	localparam int          RFC_HS_IRQ       = 1;
	localparam int          RFC_HS_FILLER    = 2;
	localparam int          RFC_HS_REFUSED   = 3;
	// Host link state
	typedef enum logic [1:0] {
		RFC_H_IDLE = 2'b01,
		RFC_H_WAIT = 2'b10
	} rfc_hstate_e;
endpackage
`default_nettype wire

// [tb.sv]
/* Bench driving the host end over AXI4-Lite and the device end's receive stream.
   Assumes the two ends meet through the link interface, one clock. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, v) begin comparisons++; if ((v) !== (e)) begin bad_count++; $display("wrong value %s exp %h got %h", n, e, v); end end
module tb;
	import rfc_pkg::*;
	logic        clk_i, nrst_i, rx_last, rx_valid, rx_ready;
	logic [31:0] rx_data, wdata, rdata, q, s;
	logic [4:0]  awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	int          bad_count, comparisons, n;
	rfc_link_if link_bus (.clk(clk_i), .nrst(nrst_i));
	rfc_dev rfc_dev_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link_bus), .rx_data_i(rx_data),
		.rx_last_i(rx_last), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready));
	rfc_host rfc_host_inst (.clk_i(clk_i), .nrst_i(nrst_i), .link(link_bus), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	rfc_link_checker rfc_link_checker_inst (.clk(clk_i), .nrst(nrst_i), .req(link_bus.req), .we(link_bus.we),
		.addr(link_bus.addr), .wdata(link_bus.wdata), .ack(link_bus.ack), .rdata(link_bus.rdata),
		.irq(link_bus.irq));
	// Clock at 25 MHz
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic conclude();
		if (bad_count == 0 && comparisons > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// AXI write: address and data offered together, each dropped once taken
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clk_i);
			aw_ok = aw_ok | awready;
			w_ok = w_ok | wready;
			awvalid <= ~aw_ok;
			wvalid <= ~w_ok;
		end
		do @(posedge clk_i); while (bvalid !== 1'b1);
		`CHK("bresp", 2'b00, bresp)
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk_i); while (rvalid !== 1'b1);
		d = rdata;
		`CHK("rresp", 2'b00, rresp)
		rready <= 1'b0;
	endtask
	// One device access through the host's command registers; st is the final status
	task automatic lk(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic [31:0] st);
		if (w) wr(RFC_H_WDATA, d);
		wr(RFC_H_CMD, {23'h0, w, a});
		st = 32'h1;
		while (st[RFC_HS_BUSY] !== 1'b0) rd(RFC_H_STATUS, st);
		rd(RFC_H_RDATA, r);
	endtask
	// Receive stream word, held until ready
	task automatic push(input logic [31:0] d, input logic last);
		@(posedge clk_i);
		rx_data <= d;
		rx_last <= last;
		rx_valid <= 1'b1;
		do @(posedge clk_i); while (rx_ready !== 1'b1);
		rx_valid <= 1'b0;
	endtask
	// Hang guard, well above the expected run length
	initial begin
		#2000000;
		bad_count++;
		conclude();
	end
	initial begin
		{nrst_i, rx_last, rx_valid, awvalid, wvalid, bready, arvalid, rready} = '0;
		{rx_data, wdata, awaddr, araddr} = '0;
		repeat (4) @(posedge clk_i);
		nrst_i <= 1'b1;
		lk(0, RFC_OFF_RX_CFG, 0, q, s);
		`CHK("cfg_reset", RFC_RX_CFG_RST, q)
		lk(1, RFC_OFF_RX_CFG, 32'h3fff_ffff, q, s);
		lk(0, RFC_OFF_RX_CFG, 0, q, s);
		`CHK("cfg_reserved", 32'h0fff_0000, q)
		// Padding per alignment code, count set to padded length
		for (int i = 0; i < 4; i++) begin
			n = (i == 1) ? 4 : (i == 2) ? 8 : 3;
			lk(1, RFC_OFF_INT_EN, {11'h0, i != 0, 20'h0}, q, s);
			lk(1, RFC_OFF_INT_STS, 32'h0010_0000, q, s);
			lk(1, RFC_OFF_RX_CFG, {i[1:0], 2'h0, n[11:0], 16'h0}, q, s);
			for (int k = 0; k < 3; k++) push(32'ha000_0000 + 4 * i + k, k == 2);
			lk(0, RFC_OFF_RX_STAT, 0, q, s);
			`CHK("stat_len", 32'h3, q)
			wr(RFC_H_PKT_LEFT, 32'h3);
			for (int k = 0; k < n; k++) begin
				lk(0, RFC_OFF_RX_DATA, 0, q, s);
				`CHK("filler", k >= 3, s[RFC_HS_FILLER])
				if (k < 3) `CHK("rx_word", 32'ha000_0000 + 4 * i + k, q)
				lk(0, RFC_OFF_INT_STS, 0, q, s);
				`CHK("dma_flag", k == n - 1, q[RFC_RXD_INT_BIT])
			end
			rd(RFC_H_STATUS, q);
			`CHK("irq_gate", i != 0, q[RFC_HS_IRQ])
			lk(0, RFC_OFF_INT_EN, 0, q, s);
			`CHK("en_read", i != 0, q[RFC_RXD_INT_BIT])
		end
		// Count rewritten in mid-countdown
		lk(1, RFC_OFF_INT_STS, 32'h0010_0000, q, s);
		lk(1, RFC_OFF_RX_CFG, 32'h0003_0000, q, s);
		for (int k = 0; k < 4; k++) push(k, k == 3);
		lk(0, RFC_OFF_RX_DATA, 0, q, s);
		lk(0, RFC_OFF_RX_CFG, 0, q, s);
		`CHK("count_down", 32'h0002_0000, q)
		lk(1, RFC_OFF_RX_CFG, 32'h0003_0000, q, s);
		for (int k = 0; k < 3; k++) begin
			lk(0, RFC_OFF_RX_DATA, 0, q, s);
			lk(0, RFC_OFF_INT_STS, 0, q, s);
			`CHK("recount", k == 2, q[RFC_RXD_INT_BIT])
		end
		// Discard empties both FIFOs, leftover status included
		push(32'h5, 1'b0);
		push(32'h6, 1'b1);
		lk(1, RFC_OFF_RX_CFG, 32'h0000_8000, q, s);
		lk(0, RFC_OFF_RX_STAT, 0, q, s);
		`CHK("stat_empty", 32'h0, q)
		lk(0, RFC_OFF_RX_CFG, 0, q, s);
		`CHK("discard_zero", 32'h0, q)
		push(32'h77, 1'b1);
		lk(0, RFC_OFF_RX_STAT, 0, q, s);
		`CHK("stat_after", 32'h1, q)
		// Alignment change while partly read is held back
		wr(RFC_H_PKT_LEFT, 32'h1);
		lk(1, RFC_OFF_RX_CFG, 32'h4000_0000, q, s);
		`CHK("cfg_refused", 1'b1, s[RFC_HS_REFUSED])
		lk(0, RFC_OFF_RX_DATA, 0, q, s);
		`CHK("data_after", 32'h77, q)
		rd(RFC_H_PKT_LEFT, q);
		`CHK("pkt_left", 32'h0, q)
		// Indirect MAC register write then read back
		lk(1, RFC_OFF_MAC_DATA, 32'h1234_5678, q, s);
		lk(1, RFC_OFF_MAC_CMD, 32'h8000_0003, q, s);
		lk(1, RFC_OFF_MAC_DATA, 32'h0, q, s);
		lk(1, RFC_OFF_MAC_CMD, 32'hc000_0003, q, s);
		lk(0, RFC_OFF_MAC_DATA, 0, q, s);
		`CHK("mac_data", 32'h1234_5678, q)
		lk(0, RFC_OFF_MAC_CMD, 0, q, s);
		`CHK("mac_cmd", 32'h4000_0003, q)
		lk(0, 8'hf0, 0, q, s);
		`CHK("unmapped", 32'h0, q)
		rd(RFC_H_CMD, q);
		`CHK("host_cmd", 32'h0000_00f0, q)
		rd(RFC_H_WDATA, q);
		`CHK("host_wdata", 32'hc000_0003, q)
		rd(5'h1c, q);
		`CHK("host_unmapped", 32'h0, q)
		conclude();
	end
endmodule
`default_nettype wire
